// [common/tel_params.svh]
// Offsets, field positions, reset values and constants of the trim bank
`ifndef TEL_PARAMS_SVH
`define TEL_PARAMS_SVH
// ========================================
// Register offsets
`define TEL_OFS_SHARE_OFFSET 8'h05
`define TEL_OFS_SHARE_SLOPE 8'h06
`define TEL_OFS_NVM_PROTECT 8'h07
`define TEL_OFS_LOAD_OV 8'h08
`define TEL_OFS_LOCAL_UV 8'h09
`define TEL_OFS_LOCAL_OV 8'h0A
`define TEL_OFS_OVERTEMP 8'h0B
`define TEL_OFS_FIRST 8'h05
`define TEL_REG_COUNT 3'h7
`define TEL_LAST_IDX 3'h6
`define TEL_REG_RESET 8'h00
// ========================================
// Nonvolatile shadow and protected ranges
`define TEL_NVM_SHADOW_BASE 16'h8100
`define TEL_NVM_R0_LO 16'h8000
`define TEL_NVM_R1_LO 16'h8040
`define TEL_NVM_R2_LO 16'h8080
`define TEL_NVM_R3_LO 16'h80C0
`define TEL_NVM_R4_LO 16'h8100
`define TEL_NVM_R5_LO 16'h8120
`define TEL_NVM_R6_LO 16'h8140
`define TEL_NVM_R6_HI 16'h817F
// ========================================
// Field positions
`define TEL_SLOPE_MSB 7
`define TEL_SLOPE_LSB 1
`define TEL_OTP_MSB 7
`define TEL_OTP_LSB 4
`define TEL_SOFT_OTP_BIT 0
`define TEL_PROTECT_MSB 6
`endif

// [common/tel_pkg.sv]
// Types and shared decode functions of the trim bank
`default_nettype none
`include "tel_params.svh"
package tel_pkg;
	typedef enum logic [1:0] {
		TEL_LOAD_REQ,
		TEL_LOAD_WAIT,
		TEL_READY
	} tel_state_e;

	typedef struct packed {
		tel_state_e st;
		logic [2:0] idx;
		logic nvm_rd;
		logic [15:0] nvm_addr;
		logic rvalid;
		logic grant;
		logic deny;
		logic monitor_ov;
		logic soft_otp;
		logic [14:0] char_trim;
		logic ready;
	} tel_top_s;

	// Hit flag and bank index of a register offset
	function automatic logic [3:0] tel_decode(input logic [7:0] ofs);
		logic [7:0] rel;
		rel = ofs - `TEL_OFS_FIRST;
		tel_decode = {(ofs >= `TEL_OFS_FIRST && ofs <= `TEL_OFS_OVERTEMP), rel[2:0]};
	endfunction

	// Ranges follow the protect bit order; lock 4 and 5 guard 32 bytes each
	function automatic logic tel_locked(input logic [15:0] a, input logic [6:0] lk);
		logic r;
		r = 1'b0;
		if (a >= `TEL_NVM_R0_LO && a < `TEL_NVM_R1_LO) r = lk[0];
		else if (a >= `TEL_NVM_R1_LO && a < `TEL_NVM_R2_LO) r = lk[1];
		else if (a >= `TEL_NVM_R2_LO && a < `TEL_NVM_R3_LO) r = lk[2];
		else if (a >= `TEL_NVM_R3_LO && a < `TEL_NVM_R4_LO) r = lk[3];
		else if (a >= `TEL_NVM_R4_LO && a < `TEL_NVM_R5_LO) r = lk[4];
		else if (a >= `TEL_NVM_R5_LO && a < `TEL_NVM_R6_LO) r = lk[5];
		else if (a >= `TEL_NVM_R6_LO && a <= `TEL_NVM_R6_HI) r = lk[6];
		tel_locked = r;
	endfunction
endpackage
`default_nettype wire

// [verilog/tel_bank_mem.sv]
// Seven-word trim storage with registered read port
`timescale 1ns/10ps
`default_nettype none
`include "tel_params.svh"
module tel_bank_mem
	import tel_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic we_in,
	input wire logic [2:0] widx_in,
	input wire logic [7:0] wdata_in,
	input wire logic rd_in,
	input wire logic rhit_in,
	input wire logic [2:0] ridx_in,
	output logic [7:0] rdata_out,
	output logic [55:0] words_out
);
	logic [7:0] mem_r [0:6];
	logic [7:0] rdata_r;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 7; i++) begin
				mem_r[i] <= `TEL_REG_RESET;
			end
			rdata_r <= `TEL_REG_RESET;
		end else begin
			if (we_in) begin
				mem_r[widx_in] <= wdata_in;
			end
			if (rd_in) begin
				rdata_r <= rhit_in ? mem_r[ridx_in] : 8'h00;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			words_out[i*8 +: 8] = mem_r[i];
		end
	end

	assign rdata_out = rdata_r;
endmodule
`default_nettype wire

// [verilog/tel_trim_regs.sv]
// Trim and nonvolatile-protect register bank with power-up shadow load
`timescale 1ns/10ps
`default_nettype none
`include "tel_params.svh"
module tel_trim_regs
	import tel_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	output logic READY_OUT,
	output logic NVM_RD_OUT,
	output logic [15:0] NVM_ADDR_OUT,
	input wire logic NVM_VALID_IN,
	input wire logic [7:0] NVM_RDATA_IN,
	input wire logic NVM_WR_REQ_IN,
	input wire logic [15:0] NVM_WR_ADDR_IN,
	output logic NVM_WR_GRANT_OUT,
	output logic NVM_WR_DENY_OUT,
	input wire logic [7:0] SLOPE_AUX_TRIM_IN,
	input wire logic FIFTH_MONITOR_INPUT_OV_IN,
	output logic FIFTH_MONITOR_OV_OUT,
	output logic SOFT_OTP_OUT,
	output logic [7:0] SHARE_OFFSET_OUT,
	output logic [6:0] SHARE_SLOPE_OUT,
	output logic [14:0] SHARE_CHAR_TRIM_OUT,
	output logic [6:0] PROTECT_MASK_OUT,
	output logic [7:0] LOAD_OV_TRIM_OUT,
	output logic [7:0] LOCAL_UV_TRIM_OUT,
	output logic [7:0] LOCAL_OV_TRIM_OUT,
	output logic [3:0] OVERTEMP_TRIM_OUT,
	output logic [7:0] OTP_REG_OUT
);
	// ========================================
	// State
	tel_top_s s_r;
	tel_top_s s_nxt;
	logic [55:0] words;
	logic [7:0] w_offset;
	logic [7:0] w_slope;
	logic [7:0] w_protect;
	logic [7:0] w_load_ov;
	logic [7:0] w_local_uv;
	logic [7:0] w_local_ov;
	logic [7:0] w_otp;
	logic [3:0] dec;
	logic mem_we;
	logic [2:0] mem_widx;
	logic [7:0] mem_wdata;
	logic [7:0] rdata;

	// Shadow location of a bank index
	function automatic logic [15:0] shadow_addr(input logic [2:0] i);
		shadow_addr = `TEL_NVM_SHADOW_BASE + {8'h00, `TEL_OFS_FIRST} + {13'h0000, i};
	endfunction

	// ========================================
	// Field views of the storage words
	assign dec = tel_decode(REG_ADDR_IN);
	assign w_offset = words[0 +: 8];
	assign w_slope = words[8 +: 8];
	assign w_protect = words[16 +: 8];
	assign w_load_ov = words[24 +: 8];
	assign w_local_uv = words[32 +: 8];
	assign w_local_ov = words[40 +: 8];
	assign w_otp = words[48 +: 8];

	// ========================================
	// Storage write arbitration
	always_comb begin
		mem_we = 1'b0;
		mem_widx = 3'h0;
		mem_wdata = 8'h00;
		// Bus writes are dropped until the shadow load is over
		case (s_r.st)
			TEL_LOAD_WAIT: begin
				mem_we = NVM_VALID_IN;
				mem_widx = s_r.idx;
				mem_wdata = NVM_RDATA_IN;
			end
			TEL_READY: begin
				mem_we = REG_WR_IN & dec[3];
				mem_widx = dec[2:0];
				mem_wdata = REG_WDATA_IN;
			end
			default: begin
				mem_we = 1'b0;
			end
		endcase
	end

	tel_bank_mem u_mem (
		.clk_in(CLK_SYS_IN),
		.nrst_in(NRST_IN),
		.we_in(mem_we),
		.widx_in(mem_widx),
		.wdata_in(mem_wdata),
		.rd_in(REG_RD_IN),
		.rhit_in(dec[3]),
		.ridx_in(dec[2:0]),
		.rdata_out(rdata),
		.words_out(words)
	);

	// ========================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.nvm_rd = 1'b0;
		s_nxt.rvalid = REG_RD_IN;
		s_nxt.grant = 1'b0;
		s_nxt.deny = 1'b0;
		case (s_r.st)
			TEL_LOAD_REQ: begin
				s_nxt.nvm_addr = shadow_addr(s_r.idx);
				s_nxt.nvm_rd = 1'b1;
				s_nxt.st = TEL_LOAD_WAIT;
			end
			TEL_LOAD_WAIT: begin
				// One request outstanding, any latency
				if (NVM_VALID_IN) begin
					if (s_r.idx == `TEL_LAST_IDX) begin
						s_nxt.st = TEL_READY;
						s_nxt.ready = 1'b1;
					end else begin
						s_nxt.idx = s_r.idx + 3'h1;
						s_nxt.st = TEL_LOAD_REQ;
					end
				end
			end
			TEL_READY: begin
				s_nxt.ready = 1'b1;
			end
			default: begin
				s_nxt.idx = 3'h0;
				s_nxt.st = TEL_LOAD_REQ;
			end
		endcase
		// Mask read live; a new lock word acts on the next request
		// range protection
		if (NVM_WR_REQ_IN) begin
			if (tel_locked(NVM_WR_ADDR_IN, w_protect[`TEL_PROTECT_MSB:0])) begin
				s_nxt.deny = 1'b1;
			end else begin
				s_nxt.grant = 1'b1;
			end
		end
		s_nxt.monitor_ov = 1'b0;
		s_nxt.soft_otp = 1'b0;
		if (FIFTH_MONITOR_INPUT_OV_IN) begin
			if (w_otp[`TEL_SOFT_OTP_BIT]) begin
				s_nxt.soft_otp = 1'b1;
			end else begin
				s_nxt.monitor_ov = 1'b1;
			end
		end
		// Aux trim is held in another bank; only sampled here
		// slope with aux trim
		s_nxt.char_trim = {w_slope[`TEL_SLOPE_MSB:`TEL_SLOPE_LSB], SLOPE_AUX_TRIM_IN};
	end

	// ========================================
	// State register
	// Storage words are cleared inside the memory itself
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			s_r <= '{
				st: TEL_LOAD_REQ,
				idx: 3'h0,
				nvm_rd: 1'b0,
				nvm_addr: 16'h0000,
				rvalid: 1'b0,
				grant: 1'b0,
				deny: 1'b0,
				monitor_ov: 1'b0,
				soft_otp: 1'b0,
				char_trim: 15'h0000,
				ready: 1'b0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ========================================
	// Outputs, all from flops here or in the storage
	assign REG_RDATA_OUT = rdata;
	assign REG_RVALID_OUT = s_r.rvalid;
	assign READY_OUT = s_r.ready;
	assign NVM_RD_OUT = s_r.nvm_rd;
	assign NVM_ADDR_OUT = s_r.nvm_addr;
	assign NVM_WR_GRANT_OUT = s_r.grant;
	assign NVM_WR_DENY_OUT = s_r.deny;
	assign FIFTH_MONITOR_OV_OUT = s_r.monitor_ov;
	assign SOFT_OTP_OUT = s_r.soft_otp;
	assign SHARE_CHAR_TRIM_OUT = s_r.char_trim;

	// ========================================
	// Register values, straight from the storage flops
	// full-range offset code
	assign SHARE_OFFSET_OUT = w_offset;
	assign SHARE_SLOPE_OUT = w_slope[`TEL_SLOPE_MSB:`TEL_SLOPE_LSB];
	assign PROTECT_MASK_OUT = w_protect[`TEL_PROTECT_MSB:0];
	assign LOAD_OV_TRIM_OUT = w_load_ov;
	assign LOCAL_UV_TRIM_OUT = w_local_uv;
	assign LOCAL_OV_TRIM_OUT = w_local_ov;
	assign OVERTEMP_TRIM_OUT = w_otp[`TEL_OTP_MSB:`TEL_OTP_LSB];
	assign OTP_REG_OUT = w_otp;
endmodule
`default_nettype wire

// [sim/tel_trim_regs_chk.sv]
// Port assertions of the trim bank
`timescale 1ns/10ps
`default_nettype none
module tel_trim_regs_chk (
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_RVALID_OUT,
	input wire logic READY_OUT,
	input wire logic NVM_RD_OUT,
	input wire logic [15:0] NVM_ADDR_OUT,
	input wire logic NVM_WR_REQ_IN,
	input wire logic [15:0] NVM_WR_ADDR_IN,
	input wire logic NVM_WR_GRANT_OUT,
	input wire logic NVM_WR_DENY_OUT,
	input wire logic FIFTH_MONITOR_INPUT_OV_IN,
	input wire logic FIFTH_MONITOR_OV_OUT,
	input wire logic SOFT_OTP_OUT,
	input wire logic [6:0] PROTECT_MASK_OUT,
	input wire logic [7:0] LOAD_OV_TRIM_OUT,
	input wire logic [7:0] OTP_REG_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!NRST_IN);
	property p_rv; REG_RD_IN |=> REG_RVALID_OUT; endproperty
	a_rv: assert property (p_rv) else $error("no read answer");
	property p_adr; NVM_RD_OUT |-> NVM_ADDR_OUT inside {[16'h8105:16'h810B]}; endproperty
	a_adr: assert property (p_adr) else $error("bad shadow address");
	property p_rdy; READY_OUT |=> READY_OUT && !NVM_RD_OUT; endproperty
	a_rdy: assert property (p_rdy) else $error("load after ready");
	property p_gd; NVM_WR_REQ_IN |=> NVM_WR_GRANT_OUT != NVM_WR_DENY_OUT; endproperty
	a_gd: assert property (p_gd) else $error("no protect answer");
	property p_lk; NVM_WR_REQ_IN && NVM_WR_ADDR_IN[15:6] == 10'h200 && PROTECT_MASK_OUT[0]
		|=> NVM_WR_DENY_OUT; endproperty
	a_lk: assert property (p_lk) else $error("locked range granted");
	property p_so; $past(NRST_IN) |->
		SOFT_OTP_OUT == $past(FIFTH_MONITOR_INPUT_OV_IN && OTP_REG_OUT[0]); endproperty
	a_so: assert property (p_so) else $error("soft event wrong");
	property p_m5; $past(NRST_IN) |->
		FIFTH_MONITOR_OV_OUT == $past(FIFTH_MONITOR_INPUT_OV_IN && !OTP_REG_OUT[0]);
		endproperty
	a_m5: assert property (p_m5) else $error("overvoltage wrong");
	property p_wr; REG_WR_IN && READY_OUT && REG_ADDR_IN == 8'h08
		|=> LOAD_OV_TRIM_OUT == $past(REG_WDATA_IN); endproperty
	a_wr: assert property (p_wr) else $error("trim not written");
	c_rv: cover property (REG_RVALID_OUT);
	c_dn: cover property (NVM_WR_DENY_OUT);
	c_so: cover property (SOFT_OTP_OUT);
endmodule
`default_nettype wire

// [sim/tel_trim_regs_tb.sv]
// Bench of the trim bank: load, access, protect, monitor
`timescale 1ns/10ps
`default_nettype none
module tel_trim_regs_tb;
	import tel_pkg::*;
	logic ck = 0, nr = 0, wr = 0, rd = 0, nv = 0, wq = 0, m5 = 0;
	logic [7:0] ad = 0, wd = 0, nd = 0, ax = 0;
	logic [15:0] wa = 0;
	wire logic [7:0] rda, so, lov, luv, lo, orr;
	wire logic rv, rdy, nrd, gr, dn, mo, sf;
	wire logic [15:0] na;
	wire logic [6:0] ss, pm;
	wire logic [14:0] ct;
	wire logic [3:0] ot;
	int fail_count = 0, comparisons = 0;
	logic [7:0] m [7];
	logic [15:0] eg [8] = '{16'h7FFF, 16'h803F, 16'h8040, 16'h80FF, 16'h811F, 16'h8120,
		16'h817F, 16'h8180};
	always #50 ck = ~ck;
	tel_trim_regs uut (.CLK_SYS_IN(ck), .NRST_IN(nr), .REG_ADDR_IN(ad), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rda), .REG_RVALID_OUT(rv),
		.READY_OUT(rdy), .NVM_RD_OUT(nrd), .NVM_ADDR_OUT(na), .NVM_VALID_IN(nv),
		.NVM_RDATA_IN(nd), .NVM_WR_REQ_IN(wq), .NVM_WR_ADDR_IN(wa), .NVM_WR_GRANT_OUT(gr),
		.NVM_WR_DENY_OUT(dn), .SLOPE_AUX_TRIM_IN(ax), .FIFTH_MONITOR_INPUT_OV_IN(m5),
		.FIFTH_MONITOR_OV_OUT(mo), .SOFT_OTP_OUT(sf), .SHARE_OFFSET_OUT(so),
		.SHARE_SLOPE_OUT(ss),
		.SHARE_CHAR_TRIM_OUT(ct), .PROTECT_MASK_OUT(pm), .LOAD_OV_TRIM_OUT(lov),
		.LOCAL_UV_TRIM_OUT(luv), .LOCAL_OV_TRIM_OUT(lo), .OVERTEMP_TRIM_OUT(ot),
		.OTP_REG_OUT(orr));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wrt(input logic [7:0] a, input logic [7:0] d);
		logic t;
		@(negedge ck);
		t = rdy;
		ad = a;
		wd = d;
		wr = 1;
		@(negedge ck);
		wr = 0;
		if (t && a > 4 && a < 12) m[a - 5] = d;
	endtask
	task automatic rdc(input logic [7:0] a);
		@(negedge ck);
		ad = a;
		rd = 1;
		@(negedge ck);
		rd = 0;
		chk(rv, 1);
		chk(rda, (a > 4 && a < 12) ? m[a - 5] : 8'h00);
	endtask
	function automatic logic lk(input int a);
		int i;
		i = (a < 'h8000 || a > 'h817F) ? 7 : (a < 'h8100) ? (a - 'h8000) / 64
			: (a < 'h8140) ? 4 + (a - 'h8100) / 32 : 6;
		return i < 7 && m[2][i];
	endfunction
	task automatic prot(input logic [15:0] a);
		@(negedge ck);
		wa = a;
		wq = 1;
		@(negedge ck);
		wq = 0;
		chk(dn, lk(a));
		chk(gr, !lk(a));
	endtask
	task automatic load();
		for (int k = 0; k < 7; k++) begin
			for (int i = 0; i < 30 && !nrd; i++) @(negedge ck);
			chk(nrd, 1);
			chk(na, 16'h8105 + k);
			@(negedge ck);
			// Early write must lose to the load
			if (k == 2) wrt(8'h08, 8'hA5);
			repeat ($urandom_range(3)) @(negedge ck);
			nd = $urandom;
			nv = 1;
			m[k] = nd;
			@(negedge ck);
			nv = 0;
		end
		chk(rdy, 1);
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#1000000;
		fail_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'h9A3444E4));
		repeat (4) @(negedge ck);
		nr = 1;
		load();
		for (int r = 0; r < 3; r++) begin
			for (int a = 4; a < 13; a++) rdc(a);
			chk(so, m[0]);
			chk(pm, m[2][6:0]);
			chk(lov, m[3]);
			chk(luv, m[4]);
			chk(lo, m[5]);
			for (int a = 5; a < 13; a++) wrt(a, $urandom);
		end
		for (int r = 0; r < 4; r++) begin
			wrt(7, $urandom);
			foreach (eg[j]) prot(eg[j]);
			repeat (8) prot(16'h7F00 + $urandom_range(767));
		end
		// Mid-run reset clears the bank and reloads it
		nr = 0;
		@(negedge ck);
		chk(rdy, 0);
		chk(lov, 0);
		nr = 1;
		load();
		for (int r = 0; r < 8; r++) begin
			wrt(6, $urandom);
			wrt(11, {$urandom, r[0]});
			m5 = r[1];
			ax = $urandom;
			@(negedge ck);
			chk(sf, m5 & m[6][0]);
			chk(mo, m5 & !m[6][0]);
			chk(ct, {m[1][7:1], ax});
			chk(ss, m[1][7:1]);
			chk(ot, m[6][7:4]);
			chk(orr, m[6]);
		end
		conclude();
	end
endmodule
bind tel_trim_regs tel_trim_regs_chk chk (.*);
`default_nettype wire
